// ### design/lsg_guard.v
// limited speed guard: clamp, fast stop, brake ramp and limit monitoring
`include "lsg_map.vh"
module lsg_guard #(
  parameter SPD_W = 16,
  parameter DLY_W = 24
) (
  input  wire                   mclk,
  input  wire                   nrst,
  input  wire [`LSG_ADDR_W-1:0] reg_addr,
  input  wire [31:0]            reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [31:0]            reg_rdata,
  input  wire                   fs_req,
  input  wire                   bus_req,
  input  wire [1:0]             bus_level,
  input  wire [SPD_W-1:0]       speed_act,
  input  wire [SPD_W-1:0]       setpoint_in,
  output reg  [SPD_W-1:0]       setpoint_out,
  output reg                    fast_stop_ramp,
  output reg                    active_out,
  output reg                    fault_out,
  output reg                    safe_stop_req,
  output wire                   irq
);
  localparam ST_IDLE = 3'h0;
  localparam ST_WAIT = 3'h1;
  localparam ST_RAMP = 3'h2;
  localparam ST_MON  = 3'h3;
  localparam ST_FLT  = 3'h4;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers; stage one feeds stage two only
  wire       fs_sync;
  wire       bq_sync;
  wire [1:0] lv_sync;

  // fail-safe request pin
  lsg_sync2 #(.W(1)) u_fs_sync (
    .mclk    (mclk),
    .nrst    (nrst),
    .din     (fs_req),
    .sync_ff (fs_sync)
  );

  // fieldbus request
  lsg_sync2 #(.W(1)) u_bq_sync (
    .mclk    (mclk),
    .nrst    (nrst),
    .din     (bus_req),
    .sync_ff (bq_sync)
  );

  // fieldbus level; rides with the request, same latency
  lsg_sync2 #(.W(2)) u_lv_sync (
    .mclk    (mclk),
    .nrst    (nrst),
    .din     (bus_level),
    .sync_ff (lv_sync)
  );

  wire req = fs_sync | bq_sync;
  // level only from the fieldbus; fail-safe alone uses level 0
  wire [1:0] lvl = bq_sync ? lv_sync : 2'h0;

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers
  reg             sbr_en_ff;
  reg [SPD_W-1:0] lim_ff [0:3];
  reg [DLY_W-1:0] ramp_dly_ff;
  reg [DLY_W-1:0] chg_dly_ff;
  reg [SPD_W-1:0] grad_ff;
  reg [`LSG_IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
  wire [`LSG_IRQ_W-1:0] irq_ev;
  integer i;

  // configuration writes; offsets without a register are ignored
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sbr_en_ff   <= 1'b0;
      for (i = 0; i < 4; i = i + 1)
        lim_ff[i] <= `LSG_LIM_RST;
      ramp_dly_ff <= `LSG_DLY_RST;
      chg_dly_ff  <= `LSG_DLY_RST;
      grad_ff     <= `LSG_GRAD_RST;
      irq_mask_ff <= {`LSG_IRQ_W{1'b0}};
    end else begin
      if (reg_wr) begin
        case (reg_addr)
          `LSG_REG_CTRL:     sbr_en_ff <= reg_wdata[`LSG_CTRL_SBR_BIT];
          `LSG_REG_LIM0:     lim_ff[0] <= reg_wdata[SPD_W-1:0];
          `LSG_REG_LIM1:     lim_ff[1] <= reg_wdata[SPD_W-1:0];
          `LSG_REG_LIM2:     lim_ff[2] <= reg_wdata[SPD_W-1:0];
          `LSG_REG_LIM3:     lim_ff[3] <= reg_wdata[SPD_W-1:0];
          `LSG_REG_RAMP_DLY: ramp_dly_ff <= reg_wdata[DLY_W-1:0];
          `LSG_REG_CHG_DLY:  chg_dly_ff <= reg_wdata[DLY_W-1:0];
          `LSG_REG_GRAD:     grad_ff <= reg_wdata[SPD_W-1:0];
          `LSG_REG_IRQ_MASK: irq_mask_ff <= reg_wdata[`LSG_IRQ_W-1:0];
          default: ;
        endcase
      end
    end
  end

  // sticky status; a hardware event wins over a clear in the same cycle
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      irq_stat_ff <= {`LSG_IRQ_W{1'b0}};
    end else if (reg_wr && reg_addr == `LSG_REG_IRQ_STAT) begin
      irq_stat_ff <= (irq_stat_ff & ~reg_wdata[`LSG_IRQ_W-1:0]) | irq_ev;
    end else begin
      irq_stat_ff <= irq_stat_ff | irq_ev;
    end
  end

  assign irq = |(irq_stat_ff & irq_mask_ff);

  ////////////////////////////////////////////////////////////////////////////
  // speed magnitude and thresholds
  wire [SPD_W-1:0] spd_abs;
  wire [SPD_W-1:0] sp_abs;

  // measured speed, sign ignored
  lsg_abs #(.W(SPD_W)) u_spd_abs (
    .val (speed_act),
    .mag (spd_abs)
  );

  // setpoint magnitude for clamp and ramp start
  lsg_abs #(.W(SPD_W)) u_sp_abs (
    .val (setpoint_in),
    .mag (sp_abs)
  );

  wire [SPD_W-1:0] thr     = lim_ff[lvl];
  wire [SPD_W-1:0] thr_m1  = (thr == {SPD_W{1'b0}}) ? thr : thr - 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer state
  reg [2:0]       st_ff, nxt_st;
  reg [1:0]       lvl_ff, nxt_lvl;
  reg [DLY_W-1:0] cnt_ff, nxt_cnt;
  reg [SPD_W-1:0] ramp_ff, nxt_ramp;
  reg [SPD_W-1:0] prev_ff;
  reg             brk_ff, nxt_brk;
  reg             flt_ev;

  // restart the sequence from request or lower level
  wire start = (st_ff == ST_IDLE && req) ||
               (st_ff != ST_IDLE && st_ff != ST_FLT && req &&
                thr < lim_ff[lvl_ff]);
  wire dly_done = (cnt_ff == {DLY_W{1'b0}});
  // ramp minus gradient, floored at zero
  wire [SPD_W-1:0] ramp_dec = (ramp_ff > grad_ff) ? ramp_ff - grad_ff
                                                  : {SPD_W{1'b0}};

  always @* begin
    nxt_st   = st_ff;
    nxt_lvl  = lvl_ff;
    nxt_cnt  = dly_done ? cnt_ff : cnt_ff - 1'b1;
    nxt_ramp = ramp_ff;
    nxt_brk  = brk_ff;
    flt_ev   = 1'b0;
    if (!req) begin
      nxt_st  = ST_IDLE;
      nxt_brk = 1'b0;
    end else if (start) begin
      nxt_lvl  = lvl;
      nxt_ramp = sp_abs;
      nxt_brk  = (spd_abs >= thr);
      nxt_cnt  = sbr_en_ff ? ramp_dly_ff : chg_dly_ff;
      nxt_st   = ST_WAIT;
    end else begin
      case (st_ff)
        ST_WAIT: begin
          if (dly_done) begin
            if (sbr_en_ff && brk_ff)
              nxt_st = ST_RAMP;
            else
              nxt_st = ST_MON;
          end else if (sbr_en_ff && brk_ff && ramp_dec <= thr) begin
            nxt_st = ST_MON;
          end
          if (sbr_en_ff)
            nxt_ramp = ramp_dec;
        end
        ST_RAMP: begin
          nxt_ramp = ramp_dec;
          if (ramp_dec <= thr || spd_abs < thr) begin
            nxt_st = ST_MON;
          end else if (spd_abs > ramp_ff || spd_abs > prev_ff) begin
            nxt_st = ST_FLT;
            flt_ev = 1'b1;
          end
        end
        ST_MON: begin
          nxt_lvl = lvl;
          nxt_brk = 1'b0;
          if (spd_abs >= thr) begin
            nxt_st = ST_FLT;
            flt_ev = 1'b1;
          end
        end
        ST_FLT:  nxt_st = ST_FLT;
        default: nxt_st = ST_IDLE;
      endcase
    end
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_ff   <= ST_IDLE;
      lvl_ff  <= 2'h0;
      cnt_ff  <= {DLY_W{1'b0}};
      ramp_ff <= {SPD_W{1'b0}};
      prev_ff <= {SPD_W{1'b0}};
      brk_ff  <= 1'b0;
    end else begin
      st_ff   <= nxt_st;
      lvl_ff  <= nxt_lvl;
      cnt_ff  <= nxt_cnt;
      ramp_ff <= nxt_ramp;
      prev_ff <= spd_abs;
      brk_ff  <= nxt_brk;
    end
  end

  assign irq_ev[`LSG_IRQ_ACT_BIT] = (nxt_st == ST_MON) && (st_ff != ST_MON);
  assign irq_ev[`LSG_IRQ_FLT_BIT] = flt_ev;

  ////////////////////////////////////////////////////////////////////////////
  // outputs from flip-flops; clamp only while the request stands
  wire clamp = req && st_ff != ST_IDLE;

  // clamped setpoint keeps its sign, magnitude one below the limit
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      setpoint_out <= {SPD_W{1'b0}};
    end else if (clamp && sp_abs > thr_m1) begin
      setpoint_out <= setpoint_in[SPD_W-1] ? (~thr_m1 + 1'b1) : thr_m1;
    end else begin
      setpoint_out <= setpoint_in;
    end
  end

  // braking and monitoring status toward the controller
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fast_stop_ramp <= 1'b0;
      active_out     <= 1'b0;
    end else begin
      fast_stop_ramp <= req && nxt_brk;
      active_out     <= req && nxt_st == ST_MON;
    end
  end

  // fault and stop request stay up until the request is withdrawn
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      fault_out     <= 1'b0;
      safe_stop_req <= 1'b0;
    end else begin
      fault_out     <= nxt_st == ST_FLT;
      safe_stop_req <= nxt_st == ST_FLT;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read, data one cycle after the strobe
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h00000000;
    end else begin
      reg_rdata <= 32'h00000000;
      if (reg_rd) begin
        case (reg_addr)
          `LSG_REG_CTRL:     reg_rdata <= {31'h0, sbr_en_ff};
          `LSG_REG_LIM0:     reg_rdata[SPD_W-1:0] <= lim_ff[0];
          `LSG_REG_LIM1:     reg_rdata[SPD_W-1:0] <= lim_ff[1];
          `LSG_REG_LIM2:     reg_rdata[SPD_W-1:0] <= lim_ff[2];
          `LSG_REG_LIM3:     reg_rdata[SPD_W-1:0] <= lim_ff[3];
          `LSG_REG_RAMP_DLY: reg_rdata[DLY_W-1:0] <= ramp_dly_ff;
          `LSG_REG_CHG_DLY:  reg_rdata[DLY_W-1:0] <= chg_dly_ff;
          `LSG_REG_GRAD:     reg_rdata[SPD_W-1:0] <= grad_ff;
          `LSG_REG_STAT:     reg_rdata <= {24'h0, lvl_ff, 1'b0, st_ff,
                                           fault_out, active_out};
          `LSG_REG_IRQ_STAT: reg_rdata[`LSG_IRQ_W-1:0] <= irq_stat_ff;
          `LSG_REG_IRQ_MASK: reg_rdata[`LSG_IRQ_W-1:0] <= irq_mask_ff;
          default:           reg_rdata <= 32'h00000000;
        endcase
      end
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// two flip-flop synchroniser; only the second stage is read outside
module lsg_sync2 #(
  parameter W = 1
) (
  input  wire         mclk,
  input  wire         nrst,
  input  wire [W-1:0] din,
  output reg  [W-1:0] sync_ff
);
  reg [W-1:0] meta_ff;

  // both stages clear in reset so no false request follows it
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      meta_ff <= {W{1'b0}};
      sync_ff <= {W{1'b0}};
    end else begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end
endmodule

////////////////////////////////////////////////////////////////////////////
// magnitude of a two's complement word; the most negative value wraps
module lsg_abs #(
  parameter W = 16
) (
  input  wire [W-1:0] val,
  output wire [W-1:0] mag
);
  // negate only when the sign bit is set
  assign mag = val[W-1] ? (~val + 1'b1) : val;
endmodule

// ### design/lsg_map.vh
// constants for the limited speed guard: offsets, fields, resets, timing
`ifndef LSG_MAP_VH
`define LSG_MAP_VH
`define LSG_ADDR_W        4
`define LSG_REG_CTRL      4'h0
`define LSG_REG_LIM0      4'h1
`define LSG_REG_LIM1      4'h2
`define LSG_REG_LIM2      4'h3
`define LSG_REG_LIM3      4'h4
`define LSG_REG_RAMP_DLY  4'h5
`define LSG_REG_CHG_DLY   4'h6
`define LSG_REG_GRAD      4'h7
`define LSG_REG_STAT      4'h8
`define LSG_REG_IRQ_STAT  4'h9
`define LSG_REG_IRQ_MASK  4'hA
`define LSG_CTRL_SBR_BIT  0
`define LSG_STAT_ACT_BIT  0
`define LSG_STAT_FLT_BIT  1
`define LSG_IRQ_ACT_BIT   0
`define LSG_IRQ_FLT_BIT   1
`define LSG_IRQ_W         2
`define LSG_LIM_RST       16'h0100
`define LSG_DLY_RST       24'h004E20
`define LSG_GRAD_RST      16'h0001
`define LSG_DLY_MS        1
`define LSG_CLK_KHZ       20000
`define LSG_DLY_CYC       (`LSG_DLY_MS * `LSG_CLK_KHZ)
`endif

// ### test/lsg_guard_sva.sv
// port assertions for the limited speed guard
module lsg_guard_sva #(
  parameter SPD_W = 16
) (
  input wire             mclk,
  input wire             nrst,
  input wire             reg_rd,
  input wire [31:0]      reg_rdata,
  input wire             fs_req,
  input wire             bus_req,
  input wire [SPD_W-1:0] setpoint_in,
  input wire [SPD_W-1:0] setpoint_out,
  input wire             fast_stop_ramp,
  input wire             active_out,
  input wire             fault_out,
  input wire             safe_stop_req
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] age_ff;
  wire        req = fs_req | bus_req;
  ////////////////////////////////////////
  // cycles the request has stood at the pins; pins lag by two syncs
  always @(posedge mclk or negedge nrst) begin
    if (!nrst)
      age_ff <= 4'h0;
    else if (!req)
      age_ff <= 4'h0;
    else if (age_ff != 4'hF)
      age_ff <= age_ff + 4'h1;
  end
  // magnitude, sign ignored
  function automatic logic [SPD_W-1:0] mag(input logic [SPD_W-1:0] v);
    return v[SPD_W-1] ? -v : v;
  endfunction
  ////////////////////////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  chk_rdata_slot: assert property (
    !$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside its slot");
  chk_clamp_shrinks: assert property (
    mag(setpoint_out) <= mag($past(setpoint_in)))
    else $error("setpoint magnitude grew");
  chk_idle_follow: assert property (
    !req [*6] |=> setpoint_out == $past(setpoint_in))
    else $error("setpoint held while idle");
  chk_drop_clears: assert property (
    !req [*6] |=> !(active_out | fast_stop_ramp | fault_out))
    else $error("outputs linger after release");
  chk_fault_stop: assert property (
    fault_out |-> safe_stop_req)
    else $error("fault without safe stop");
  chk_fault_holds: assert property (
    req [*3] ##0 fault_out |=> fault_out)
    else $error("fault cleared under request");
  chk_active_cause: assert property (
    $rose(active_out) |-> age_ff >= 4'h3)
    else $error("active without settled request");
  chk_brake_cause: assert property (
    $rose(fast_stop_ramp) |-> age_ff >= 4'h2)
    else $error("braking without request");
  cov_active: cover property ($rose(active_out));
  cov_brake: cover property ($rose(fast_stop_ramp));
  cov_fault: cover property ($rose(fault_out));
endmodule
bind lsg_guard lsg_guard_sva #(.SPD_W(SPD_W)) u_sva (
  .mclk(mclk), .nrst(nrst), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .fs_req(fs_req), .bus_req(bus_req), .setpoint_in(setpoint_in),
  .setpoint_out(setpoint_out), .fast_stop_ramp(fast_stop_ramp),
  .active_out(active_out), .fault_out(fault_out),
  .safe_stop_req(safe_stop_req));

// ### test/lsg_motor_model.sv
// motor and telegram stand-in on the far side of the guard
module lsg_motor_model (
  input  wire               mclk,
  input  wire               nrst,
  input  wire               cmd_bus,
  input  wire [1:0]         cmd_level,
  input  wire signed [15:0] step,
  input  wire signed [15:0] setpoint_out,
  output logic              bus_req,
  output logic [1:0]        bus_level,
  output logic signed [15:0] speed_act
);
  timeunit 1ns;
  timeprecision 1ns;
  // level rides with the request; between telegrams it wanders
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      bus_req <= 1'b0;
      bus_level <= 2'h0;
      speed_act <= 16'h0000;
    end else begin
      bus_req <= cmd_bus;
      bus_level <= cmd_bus ? cmd_level : ~bus_level;
      // shaft slews toward the clamped setpoint
      if (speed_act + step < setpoint_out)
        speed_act <= speed_act + step;
      else if (speed_act - step > setpoint_out)
        speed_act <= speed_act - step;
      else
        speed_act <= setpoint_out;
    end
  end
endmodule

// ### test/lsg_guard_tb.sv
// self-checking bench for the limited speed guard
`include "lsg_map.vh"
module lsg_guard_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        mclk, nrst, reg_wr, reg_rd, fs_req, cmd_bus, bus_req;
  logic        fsr, act, flt, ssr, irq, saw_fsr;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata;
  logic [1:0]  lvl, bus_level;
  logic [15:0] spd, sp_in, sp_out, step;
  logic [15:0] lim [4] = '{16'h0100, 16'h0200, 16'h0300, 16'h0400};
  int          mismatches, checked, n, t_plain;
  lsg_guard dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .fs_req(fs_req), .bus_req(bus_req),
    .bus_level(bus_level), .speed_act(spd), .setpoint_in(sp_in),
    .setpoint_out(sp_out), .fast_stop_ramp(fsr), .active_out(act),
    .fault_out(flt), .safe_stop_req(ssr), .irq(irq));
  lsg_motor_model motor (.mclk(mclk), .nrst(nrst), .cmd_bus(cmd_bus),
    .cmd_level(lvl), .step(step), .setpoint_out(sp_out),
    .bus_req(bus_req), .bus_level(bus_level), .speed_act(spd));
  ////////////////////////////////////////
  // clock; watchdog far beyond the few thousand cycles needed
  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end
  initial begin
    #1000000;
    mismatches++;
    close_out();
  end
  always @(negedge mclk) if (fsr === 1'b1) saw_fsr = 1'b1;
  ////////////////////////////////////////
  task automatic close_out();
    if (mismatches == 0 && checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(string w, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wr(logic [3:0] a, logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
    @(posedge mclk);
  endtask
  // data stand only in the cycle after the strobe
  task automatic rdchk(string w, logic [3:0] a, logic [31:0] e, m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    @(negedge mclk);
    chk(w, e, reg_rdata & m);
    @(posedge mclk);
  endtask
  task automatic wait_act(logic v);
    n = 0;
    do begin
      @(negedge mclk);
      n++;
    end while (act !== v && n < 2000);
    chk("active_out", 32'(v), 32'(act));
    @(posedge mclk);
  endtask
  // spin up, request level i over the telegram, wait for monitoring
  task automatic run(int i);
    sp_in <= 16'h0500;
    lvl <= 2'(i);
    repeat (100) @(posedge mclk);
    saw_fsr = 1'b0;
    cmd_bus <= 1'b1;
    wait_act(1'b1);
    chk("braked", 1, 32'(saw_fsr));
    chk("clamp", 1, 32'(sp_out < lim[i]));
    chk("fault", 0, 32'(flt));
    cmd_bus <= 1'b0;
    repeat (10) @(posedge mclk);
  endtask
  ////////////////////////////////////////
  initial begin
    {nrst, reg_wr, reg_rd, fs_req, cmd_bus, saw_fsr} = '0;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    lvl = 2'h0;
    sp_in = 16'h0000;
    step = 16'h0010;
    repeat (12) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rdchk("lim rst", `LSG_REG_LIM3, 32'(`LSG_LIM_RST), '1);
    rdchk("dly rst", `LSG_REG_CHG_DLY, 32'(`LSG_DLY_RST), '1);
    rdchk("grad rst", `LSG_REG_GRAD, 32'(`LSG_GRAD_RST), '1);
    wr(4'hF, 32'hFFFF);
    rdchk("hole", 4'hF, 32'h0, '1);
    for (int i = 0; i < 4; i++) wr(4'(`LSG_REG_LIM0 + i), 32'(lim[i]));
    wr(`LSG_REG_CHG_DLY, 32'h64);
    wr(`LSG_REG_RAMP_DLY, 32'h5);
    wr(`LSG_REG_IRQ_MASK, 32'h3);
    // slow reverse run on the fail-safe pin: no braking, then delay
    sp_in <= 16'hFF80;
    repeat (20) @(posedge mclk);
    fs_req <= 1'b1;
    wait_act(1'b1);
    chk("delay", 1, 32'(n > 100));
    chk("no brake", 0, 32'(saw_fsr));
    rdchk("stat", `LSG_REG_STAT, 32'h1, 32'h3);
    chk("irq", 1, 32'(irq));
    wr(`LSG_REG_IRQ_MASK, 32'h0);
    @(negedge mclk);
    chk("irq masked", 0, 32'(irq));
    @(posedge mclk);
    wr(`LSG_REG_IRQ_STAT, 32'h1);
    wr(`LSG_REG_IRQ_MASK, 32'h3);
    rdchk("irq clr", `LSG_REG_IRQ_STAT, 32'h0, 32'h1);
    fs_req <= 1'b0;
    wait_act(1'b0);
    chk("release", 1, 32'(n < 8));
    // every level on the plain delay, then level 0 with ramp supervision
    run(0);
    t_plain = n;
    for (int i = 1; i < 4; i++) run(i);
    wr(`LSG_REG_CTRL, 32'h1);
    wr(`LSG_REG_GRAD, 32'h8);
    run(0);
    chk("sooner", 1, 32'(n < t_plain));
    // sluggish motor under a steep ramp must trip
    repeat (100) @(posedge mclk);
    wr(`LSG_REG_GRAD, 32'h40);
    step <= 16'h0002;
    cmd_bus <= 1'b1;
    repeat (40) @(posedge mclk);
    @(negedge mclk);
    chk("fault", 1, 32'(flt));
    chk("safe stop", 1, 32'(ssr));
    @(posedge mclk);
    rdchk("flt irq", `LSG_REG_IRQ_STAT, 32'h2, 32'h2);
    cmd_bus <= 1'b0;
    repeat (6) @(posedge mclk);
    wait_act(1'b0);
    chk("fault clr", 0, 32'(flt));
    // reverse speed: level raised at once, lowered with a fresh brake
    wr(`LSG_REG_CTRL, 32'h0);
    step <= 16'h0010;
    sp_in <= 16'h0080;
    repeat (100) @(posedge mclk);
    cmd_bus <= 1'b1;
    wait_act(1'b1);
    lvl <= 2'h3;
    sp_in <= 16'hFD00;
    repeat (60) @(posedge mclk);
    chk("raised", 0, 32'(flt));
    saw_fsr = 1'b0;
    lvl <= 2'h0;
    wait_act(1'b0);
    wait_act(1'b1);
    chk("rebrake", 1, 32'(saw_fsr));
    chk("rebrake flt", 0, 32'(flt));
    close_out();
  end
endmodule
